/* File: rtl/serial_port_pkg.sv */
package serial_port_pkg;

  // Transaction control bytes
  localparam logic [7:0] CTL_SEND  = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h01;
  localparam logic [7:0] CTL_READ  = 8'h02;
  localparam logic [7:0] CTL_POLL  = 8'h03;

  // Command codes
  localparam logic [7:0] CMD_IDENT = 8'h01;
  localparam logic [7:0] CMD_PROTO = 8'h02;
  localparam logic [7:0] CMD_XCHG  = 8'h04;
  localparam logic [7:0] CMD_WAIT  = 8'h07;
  localparam logic [7:0] CMD_REGISTER_READ_CMD = 8'h08;
  localparam logic [7:0] CMD_REGISTER_WRITE_CMD = 8'h09;
  localparam logic [7:0] CMD_SPEED = 8'h0A;
  localparam logic [7:0] CMD_ECHO  = 8'h55;

  // Reply bytes
  localparam logic [7:0] LEN_ZERO  = 8'h00;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam logic [7:0] ERR_FULL  = 8'h8F;
  localparam logic [7:0] ECHO_LIMIT = 8'hFF;

  // Flag byte layout
  localparam int FLAG_RD_BIT = 3;
  localparam int FLAG_WR_BIT = 2;

  // Timing
  localparam int CLK_HZ      = 100_000_000;
  localparam int CLK_NS      = 1_000_000_000 / CLK_HZ;
  localparam int WAKE_LOW_NS = 10_000;
  localparam logic [9:0] WAKE_CYCLES =
    10'((WAKE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam int BAUD_DEFAULT = 57_600;
  localparam logic [15:0] ETU_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT);
  localparam int STOP_ETUS = 2;
  localparam logic [3:0] UART_FRAME_BITS = 4'(1 + 8 + STOP_ETUS);
  localparam logic [3:0] UART_STOP_LAST = 4'(STOP_ETUS);
  localparam int BUF_DEPTH = 2;

  typedef enum logic [3:0] {
    K_NONE, K_IDENT, K_PROTO, K_XCHG, K_WAIT,
    K_REGISTER_READ_CMD, K_REGISTER_WRITE_CMD, K_SPEED, K_RSVD
  } cmd_kind_t;

  typedef enum logic [1:0] {PW_UP, PW_READY, PW_WAIT} pwr_t;

  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } cmd_byte_t;

endpackage : serial_port_pkg

/* File: rtl/cmd_byte_buffer.sv */
`timescale 1ns/1ps
module cmd_byte_buffer (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  // Filling side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire serial_port_pkg::cmd_byte_t in_data,
  // Draining side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output serial_port_pkg::cmd_byte_t      out_data
);

  typedef struct packed {
    serial_port_pkg::cmd_byte_t [serial_port_pkg::BUF_DEPTH-1:0] mem;
    logic                                                   wp;
    logic                                                   rp;
    logic [1:0]                                             count;
  } buf_state_t;

  buf_state_t st;
  buf_state_t next_st;

  assign in_ready  = st.count != 2'(serial_port_pkg::BUF_DEPTH);
  assign out_valid = st.count != 2'h0;
  assign out_data  = st.mem[st.rp];

  always_comb begin
    logic push;
    logic pop;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = ~st.wp;
    end
    if (pop) begin
      next_st.rp = ~st.rp;
    end
    next_st.count = st.count + 2'(push) - 2'(pop);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : cmd_byte_buffer

/* File: rtl/host_serial_command_port.sv */
//
// Overview of operation
// - UART characters go LSB first; stop bit lasts two ETUs.
// - Wake pulse on shared receive pin is never taken as a start bit.
// - Repeated echoes regain framing; by 255 the device replies buffer full.
// - SPI control byte: 0x00 send, 0x03 poll flags, 0x02 read data.
// - Slave select high: ignore master data, serial output floats.
// - Flag bit 3 set when a response can be read.
// - Flag bit 2 set when command data is accepted; other bits meaningless.
// - SPI data sampled on rising serial clock edge.
// - Host may poll repeatedly in one transaction or in many.
// - Device ready for a command after a wake event; no poll needed first.
// - Control 0x01 resets controller at select rise; wake on low input.
// - SPI bytes move MSB first.
// - SPI mode: interrupt output low while a reply waits unread.
// - Frames are code, length, then 0 to 255 data bytes.
// - Echo is lone byte 0x55, answered with lone 0x55.
// - Decoder knows 0x01 identify, 0x02 protocol select, 0x04 exchange.
// - Command 0x07 enters low-power wait until a wake event.
// - Codes 0x08 and 0x09 read and write configuration registers.
// - Code 0x0A sets UART speed; unlisted codes are reserved.
// - Strap0 high, strap1 low picks SPI; both low pick UART.
`timescale 1ns/1ps
module host_serial_command_port (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  // Interface straps
  input  wire logic                       port_select_strap0,
  input  wire logic                       port_select_strap1,
  // SPI pins
  input  wire logic                       spi_sck,
  input  wire logic                       spi_ss_n,
  input  wire logic                       spi_mosi,
  output logic                            spi_miso_out,
  output logic                            spi_miso_oe_n,
  // Shared receive / interrupt-in and transmit / interrupt-out pins
  input  wire logic                       rx_irq_in_n,
  output logic                            tx_irq_out_n,
  // UART bit time in clock cycles, from the speed setting
  input  wire logic [15:0]                uart_etu,
  // Command bytes toward the controller
  output logic                            cmd_valid,
  input  wire logic                       cmd_ready,
  output serial_port_pkg::cmd_byte_t      cmd_byte,
  output serial_port_pkg::cmd_kind_t      cmd_kind,
  // Response bytes from the controller
  input  wire logic                       rsp_valid,
  output logic                            rsp_ready,
  input  wire logic [7:0]                 rsp_data,
  // Power state
  output logic                            ctrl_reset,
  output logic                            low_power_wait,
  output logic                            wake,
  output logic                            spi_selected
);

  typedef enum logic [2:0] {
    SP_CTL, SP_SEND, SP_POLL, SP_READ, SP_IGN
  } spi_ph_t;
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} urx_t;
  typedef enum logic [1:0] {FR_CMD, FR_LEN, FR_DATA} frm_t;

  typedef struct packed {
    logic                       sck_s1, sck_s2, sck_s3;
    logic                       ss_s1, ss_s2, mosi_s1, mosi_s2;
    logic                       rx_s1, rx_s2;
    logic                       st0_s1, st0_s2, st1_s1, st1_s2;
    spi_ph_t                    spi_ph;
    logic [2:0]                 bit_cnt;
    logic [7:0]                 sh_in;
    logic [7:0]                 sh_out;
    logic                       rst_arm;
    logic                       spi_sel;
    serial_port_pkg::pwr_t      pwr;
    logic [9:0]                 wake_cnt;
    logic                       rx_arm;
    frm_t                       frm;
    logic [7:0]                 left;
    logic [7:0]                 echo_cnt;
    serial_port_pkg::cmd_kind_t kind;
    logic [1:0]                 loc_cnt;
    logic [7:0]                 loc_b0, loc_b1;
    urx_t                       urx;
    logic [16:0]                urx_cnt;
    logic [2:0]                 urx_bit;
    logic [7:0]                 urx_sh;
    logic [15:0]                utx_cnt;
    logic [3:0]                 utx_bits;
    logic [10:0]                utx_sh;
    logic                       pin_tx;
    logic                       ctrl_reset, wake;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;
  logic        buf_push;
  logic        buf_ready;
  serial_port_pkg::cmd_byte_t buf_in;
  logic        avail;
  logic        take;
  logic        got;
  logic [7:0]  gb;

  function automatic serial_port_pkg::cmd_kind_t decode_kind(
    input logic [7:0] c);
    case (c)
      serial_port_pkg::CMD_IDENT: decode_kind = serial_port_pkg::K_IDENT;
      serial_port_pkg::CMD_PROTO: decode_kind = serial_port_pkg::K_PROTO;
      serial_port_pkg::CMD_XCHG:  decode_kind = serial_port_pkg::K_XCHG;
      serial_port_pkg::CMD_WAIT:  decode_kind = serial_port_pkg::K_WAIT;
      serial_port_pkg::CMD_REGISTER_READ_CMD: decode_kind = serial_port_pkg::K_REGISTER_READ_CMD;
      serial_port_pkg::CMD_REGISTER_WRITE_CMD: decode_kind = serial_port_pkg::K_REGISTER_WRITE_CMD;
      serial_port_pkg::CMD_SPEED: decode_kind = serial_port_pkg::K_SPEED;
      default:                    decode_kind = serial_port_pkg::K_RSVD;
    endcase
  endfunction : decode_kind

  function automatic logic [7:0] flag_byte(input logic rd, input logic wr);
    flag_byte = 8'h00;
    flag_byte[serial_port_pkg::FLAG_RD_BIT] = rd;
    flag_byte[serial_port_pkg::FLAG_WR_BIT] = wr;
  endfunction : flag_byte

  cmd_byte_buffer cmd_byte_buffer_inst (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (buf_push),
    .in_ready  (buf_ready),
    .in_data   (buf_in),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  (cmd_byte)
  );

  assign spi_miso_out   = st.sh_out[7];
  assign spi_miso_oe_n  = st.ss_s2 || !st.spi_sel;
  assign tx_irq_out_n   = st.pin_tx;
  assign cmd_kind       = st.kind;
  assign ctrl_reset     = st.ctrl_reset;
  assign wake           = st.wake;
  assign low_power_wait = st.pwr == serial_port_pkg::PW_WAIT;
  assign spi_selected   = st.spi_sel;
  assign avail          = (st.loc_cnt != 2'h0) || rsp_valid;
  assign rsp_ready      = take && (st.loc_cnt == 2'h0);

  always_comb begin
    logic       rise;
    logic       fall;
    logic       rdy;
    logic [7:0] b;
    logic [7:0] tb;
    rise = st.sck_s2 && !st.sck_s3;
    fall = !st.sck_s2 && st.sck_s3;
    rdy = st.pwr == serial_port_pkg::PW_READY;
    b = {st.sh_in[6:0], st.mosi_s2};
    tb = (st.loc_cnt != 2'h0) ? st.loc_b0 : rsp_data;
    next_st = st;
    take = 1'b0;
    got = 1'b0;
    gb = st.urx_sh;
    buf_push = 1'b0;
    buf_in = '0;
    next_st.sck_s1 = spi_sck;
    next_st.sck_s2 = st.sck_s1;
    next_st.sck_s3 = st.sck_s2;
    next_st.ss_s1 = spi_ss_n;
    next_st.ss_s2 = st.ss_s1;
    next_st.mosi_s1 = spi_mosi;
    next_st.mosi_s2 = st.mosi_s1;
    next_st.rx_s1 = rx_irq_in_n;
    next_st.rx_s2 = st.rx_s1;
    next_st.st0_s1 = port_select_strap0;
    next_st.st0_s2 = st.st0_s1;
    next_st.st1_s1 = port_select_strap1;
    next_st.st1_s2 = st.st1_s1;
    next_st.ctrl_reset = 1'b0;
    next_st.wake = 1'b0;

    // SPI slave, only while selected by strap and awake
    if (st.ss_s2 || !st.spi_sel || !rdy) begin
      next_st.spi_ph = SP_CTL;
      next_st.bit_cnt = 3'h0;
      next_st.sh_out = serial_port_pkg::FILL_BYTE;
    end else begin
      if (rise) begin
        next_st.sh_in = b;
        next_st.bit_cnt = st.bit_cnt + 3'h1;
        if (st.bit_cnt == 3'h7) begin
          case (st.spi_ph)
            SP_CTL: begin
              case (b)
                serial_port_pkg::CTL_SEND: next_st.spi_ph = SP_SEND;
                serial_port_pkg::CTL_POLL: begin
                  next_st.spi_ph = SP_POLL;
                  next_st.sh_out = flag_byte(avail, buf_ready);
                end
                serial_port_pkg::CTL_READ: begin
                  next_st.spi_ph = SP_READ;
                  take = avail;
                  next_st.sh_out = avail ? tb
                                   : serial_port_pkg::FILL_BYTE;
                end
                serial_port_pkg::CTL_RESET: begin
                  next_st.spi_ph = SP_IGN;
                  next_st.rst_arm = 1'b1;
                end
                default: next_st.spi_ph = SP_IGN;
              endcase
            end
            SP_SEND: begin
              got = 1'b1;
              gb = b;
            end
            SP_POLL: next_st.sh_out = flag_byte(avail, buf_ready);
            SP_READ: begin
              take = avail;
              next_st.sh_out = avail ? tb : serial_port_pkg::FILL_BYTE;
            end
            default: next_st.spi_ph = SP_IGN;
          endcase
        end
      end else if (fall && st.bit_cnt != 3'h0) begin
        next_st.sh_out = {st.sh_out[6:0], 1'b0};
      end
    end

    // UART receiver, armed only after the line has been seen high
    if (!rdy || st.spi_sel) begin
      next_st.urx = RX_IDLE;
    end else begin
      if (st.rx_s2) begin
        next_st.rx_arm = 1'b1;
      end
      case (st.urx)
        RX_IDLE: begin
          if (st.rx_arm && !st.rx_s2) begin
            next_st.urx = RX_DATA;
            next_st.urx_bit = 3'h0;
            next_st.urx_cnt = {1'b0, uart_etu}
                              + {2'b00, uart_etu[15:1]} - 17'h1;
          end
        end
        RX_DATA: begin
          next_st.urx_cnt = st.urx_cnt - 17'h1;
          if (st.urx_cnt == 17'h0) begin
            next_st.urx_sh = {st.rx_s2, st.urx_sh[7:1]};
            next_st.urx_bit = st.urx_bit + 3'h1;
            next_st.urx_cnt = {1'b0, uart_etu} - 17'h1;
            if (st.urx_bit == 3'h7) begin
              next_st.urx = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          next_st.urx_cnt = st.urx_cnt - 17'h1;
          if (st.urx_cnt == 17'h0) begin
            got = st.rx_s2;
            next_st.urx = RX_IDLE;
          end
        end
        default: next_st.urx = RX_IDLE;
      endcase
    end

    // UART transmitter: start, 8 data, two stop ETUs
    if (st.utx_bits != 4'h0) begin
      next_st.utx_cnt = st.utx_cnt - 16'h1;
      if (st.utx_cnt == 16'h0) begin
        next_st.utx_sh = {1'b1, st.utx_sh[10:1]};
        next_st.utx_bits = st.utx_bits - 4'h1;
        next_st.utx_cnt = uart_etu - 16'h1;
      end
    end else if (!st.spi_sel && rdy && avail) begin
      take = 1'b1;
      next_st.utx_sh = {2'b11, tb, 1'b0};
      next_st.utx_bits = serial_port_pkg::UART_FRAME_BITS;
      next_st.utx_cnt = uart_etu - 16'h1;
    end

    if (take && st.loc_cnt != 2'h0) begin
      next_st.loc_b0 = st.loc_b1;
      next_st.loc_cnt = st.loc_cnt - 2'h1;
    end

    // Frame parser; lost bytes show as a cleared ready flag
    if (got) begin
      buf_in.data = gb;
      buf_push = 1'b1;
      case (st.frm)
        FR_CMD: begin
          next_st.echo_cnt = 8'h00;
          if (gb == serial_port_pkg::CMD_ECHO) begin
            buf_push = 1'b0;
            next_st.loc_cnt = 2'h1;
            next_st.loc_b0 = serial_port_pkg::CMD_ECHO;
          end else begin
            buf_in.first = 1'b1;
            next_st.kind = decode_kind(gb);
            next_st.frm = FR_LEN;
          end
        end
        FR_LEN: begin
          next_st.left = gb;
          next_st.frm = (gb == serial_port_pkg::LEN_ZERO) ? FR_CMD : FR_DATA;
        end
        FR_DATA: begin
          next_st.left = st.left - 8'h1;
          if (st.left == 8'h1) begin
            next_st.frm = FR_CMD;
          end
          if (gb == serial_port_pkg::CMD_ECHO) begin
            next_st.echo_cnt = st.echo_cnt + 8'h1;
            if (st.echo_cnt == serial_port_pkg::ECHO_LIMIT - 8'h1) begin
              next_st.frm = FR_CMD;
              next_st.loc_cnt = 2'h2;
              next_st.loc_b0 = serial_port_pkg::ERR_FULL;
              next_st.loc_b1 = serial_port_pkg::LEN_ZERO;
            end
          end
        end
        default: next_st.frm = FR_CMD;
      endcase
      if (st.frm != FR_CMD && next_st.frm == FR_CMD
          && st.kind == serial_port_pkg::K_WAIT) begin
        next_st.pwr = serial_port_pkg::PW_WAIT;
        next_st.rx_arm = 1'b0;
      end
    end

    // Reset from control byte takes effect at deselect
    if (st.ss_s2) begin
      next_st.rst_arm = 1'b0;
      if (st.rst_arm) begin
        next_st.pwr = serial_port_pkg::PW_UP;
        next_st.ctrl_reset = 1'b1;
        next_st.frm = FR_CMD;
        next_st.loc_cnt = 2'h0;
        next_st.rx_arm = 1'b0;
      end
    end

    // Wake on a long enough low on the interrupt input
    if (!rdy) begin
      next_st.wake_cnt = st.rx_s2 ? 10'h000 : st.wake_cnt + 10'h001;
      if (st.wake_cnt == serial_port_pkg::WAKE_CYCLES) begin
        next_st.pwr = serial_port_pkg::PW_READY;
        next_st.wake = 1'b1;
        next_st.rx_arm = 1'b0;
        next_st.wake_cnt = 10'h000;
        next_st.spi_sel = st.st0_s2 && !st.st1_s2;
      end
    end

    next_st.pin_tx = st.spi_sel ? !(rdy && avail)
                     : (rdy ? st.utx_sh[0] : 1'b1);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '0;
      st.ss_s1 <= 1'b1;
      st.ss_s2 <= 1'b1;
      st.rx_s1 <= 1'b1;
      st.rx_s2 <= 1'b1;
      st.utx_sh <= '1;
      st.pin_tx <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  chk_miso_float: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st.ss_s2 |-> spi_miso_oe_n && !(got && st.spi_sel))
    else $error("miso driven or data taken while deselected");

  chk_stop_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!st.spi_sel && st.pwr == serial_port_pkg::PW_READY
     && st.utx_bits != 4'h0
     && st.utx_bits <= serial_port_pkg::UART_STOP_LAST)
    |=> tx_irq_out_n)
    else $error("uart stop bit not high");

  chk_wake_disarm: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wake |-> !st.rx_arm ##1 (st.urx == RX_IDLE))
    else $error("wake pulse could start a character");

  chk_echo_reply: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (got && st.frm == FR_CMD && gb == serial_port_pkg::CMD_ECHO)
    |=> st.loc_cnt == 2'h1
        && st.loc_b0 == serial_port_pkg::CMD_ECHO)
    else $error("echo not answered");

  chk_echo_limit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (got && st.frm == FR_DATA && gb == serial_port_pkg::CMD_ECHO
     && st.echo_cnt == 8'hFE)
    |=> st.loc_b0 == serial_port_pkg::ERR_FULL && st.frm == FR_CMD)
    else $error("buffer full reply missing");

  chk_poll_flags: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st.spi_ph == SP_POLL && $rose(st.sh_out[7:0] != 8'h00))
    |-> (st.sh_out & 8'hF3) == 8'h00)
    else $error("meaningless flag bits set");

  chk_irq_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st.spi_sel && st.pwr == serial_port_pkg::PW_READY && avail)
    |=> !tx_irq_out_n)
    else $error("interrupt not asserted for waiting reply");

  chk_reset_deferred: assert property (@(posedge ref_clk)
    disable iff (!reset_n)
    (st.rst_arm && st.ss_s2) |=> ctrl_reset
      && st.pwr == serial_port_pkg::PW_UP ##1 !ctrl_reset)
    else $error("spi reset not applied at deselect");

  chk_wait_entry: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (got && st.frm == FR_LEN && gb == serial_port_pkg::LEN_ZERO
     && st.kind == serial_port_pkg::K_WAIT && !st.ss_s2)
    |=> low_power_wait)
    else $error("wait command did not enter wait state");

endmodule : host_serial_command_port

/* File: tb/spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input  wire logic ref_clk,
  // SPI pins
  output logic      spi_sck,
  output logic      spi_ss_n,
  output logic      spi_mosi,
  input  wire logic spi_miso_out,
  input  wire logic spi_miso_oe_n
);
  logic [7:0]  rx_last;
  logic [23:0] rx_word;

  initial begin
    spi_sck  = 1'b0;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // Deselected data line toggles so stale bits never look valid
  always @(posedge ref_clk) begin
    if (spi_ss_n) begin
      spi_mosi <= ~spi_mosi;
    end
  end

  // Half period of eight ref_clk cycles gives the 160 ns link clock
  task xfer(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi <= tx[i];
      repeat (8) @(posedge ref_clk);
      spi_sck <= 1'b1;
      // Released line shows the inverse of its last bit
      rx_last[i] = spi_miso_oe_n ? ~rx_last[i] : spi_miso_out;
      repeat (8) @(posedge ref_clk);
      spi_sck <= 1'b0;
    end
    rx_word = {rx_word[15:0], rx_last};
  endtask : xfer

  // Select stays low for the whole transaction, high between them
  task run(input logic [7:0] ctl, input logic [23:0] data, input int n);
    spi_ss_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    xfer(ctl);
    for (int k = 0; k < n; k++) begin
      xfer(data[23-8*k -: 8]);
    end
    repeat (8) @(posedge ref_clk);
    spi_ss_n <= 1'b1;
    repeat (16) @(posedge ref_clk);
  endtask : run
endmodule : spi_host_model

/* File: tb/test_host_serial_command_port.sv */
`timescale 1ns/1ps
module test_host_serial_command_port;
  logic                       ref_clk, reset_n, strap0, strap1, rx_irq_in_n;
  logic [9:0]                 ub;
  logic                       cmd_ready, rsp_valid, rsp_ready, cmd_valid;
  logic                       sck, ss_n, mosi, miso_out, miso_oe_n;
  logic                       tx_irq_out_n, ctrl_reset, low_power_wait;
  logic                       wake, spi_selected;
  logic [7:0]                 rsp_data;
  serial_port_pkg::cmd_byte_t cmd_byte;
  serial_port_pkg::cmd_kind_t cmd_kind;
  logic [8:0]                 cq[$];
  logic [7:0]                 rq[$];
  int                         n_mismatch = 0;
  int                         n_compared = 0;
  int                         n_wake = 0;
  int                         n_rst = 0;
  logic [7:0]                 codes[6] = '{8'h02, 8'h04, 8'h08, 8'h09,
                                           8'h0A, 8'h03};
  serial_port_pkg::cmd_kind_t kinds[6] = '{serial_port_pkg::K_PROTO,
    serial_port_pkg::K_XCHG, serial_port_pkg::K_REGISTER_READ_CMD,
    serial_port_pkg::K_REGISTER_WRITE_CMD, serial_port_pkg::K_SPEED,
    serial_port_pkg::K_RSVD};

  host_serial_command_port host_serial_command_port_inst (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .port_select_strap0(strap0), .port_select_strap1(strap1),
    .spi_sck(sck), .spi_ss_n(ss_n), .spi_mosi(mosi),
    .spi_miso_out(miso_out), .spi_miso_oe_n(miso_oe_n),
    .rx_irq_in_n(rx_irq_in_n), .tx_irq_out_n(tx_irq_out_n),
    .uart_etu(16'h0010), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_byte(cmd_byte), .cmd_kind(cmd_kind), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_data(rsp_data), .ctrl_reset(ctrl_reset),
    .low_power_wait(low_power_wait), .wake(wake),
    .spi_selected(spi_selected));

  spi_host_model spi_host_model_inst (
    .ref_clk(ref_clk), .spi_sck(sck), .spi_ss_n(ss_n), .spi_mosi(mosi),
    .spi_miso_out(miso_out), .spi_miso_oe_n(miso_oe_n));

  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  // Controller stand-in: takes command bytes, offers queued replies
  always @(posedge ref_clk) begin
    if (cmd_valid === 1'b1 && cmd_ready) cq.push_back(cmd_byte);
    if (rsp_valid && rsp_ready === 1'b1) void'(rq.pop_front());
    rsp_valid <= rq.size() > 0;
    rsp_data  <= (rq.size() > 0) ? rq[0] : ~rsp_data;
    if (wake === 1'b1) n_wake++;
    if (ctrl_reset === 1'b1) n_rst++;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task close_out;
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task poll(input logic [1:0] exp);
    spi_host_model_inst.run(serial_port_pkg::CTL_POLL, 24'h0, 1);
    check(16'(spi_host_model_inst.rx_word[3:2]), 16'(exp));
  endtask : poll

  task send2(input logic [7:0] code);
    cq.delete();
    spi_host_model_inst.run(serial_port_pkg::CTL_SEND, {code, 16'h0}, 2);
  endtask : send2

  task wake_up;
    rx_irq_in_n <= 1'b0;
    repeat (1010) @(posedge ref_clk);
    rx_irq_in_n <= 1'b1;
    repeat (20) @(posedge ref_clk);
  endtask : wake_up

  task uart_send(input logic [7:0] c);
    rx_irq_in_n <= 1'b0;
    repeat (16) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      rx_irq_in_n <= c[i];
      repeat (16) @(posedge ref_clk);
    end
    rx_irq_in_n <= 1'b1;
    repeat (32) @(posedge ref_clk);
  endtask : uart_send

  // Samples mid-bit: eight data bits, then both stop ETUs
  task uart_take(output logic [9:0] rb);
    int w;
    w = 0;
    while (tx_irq_out_n !== 1'b0 && w < 400) begin
      @(posedge ref_clk);
      w++;
    end
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      repeat (16) @(posedge ref_clk);
      rb[i] = tx_irq_out_n;
    end
  endtask : uart_take

  initial begin
    reset_n = 1'b0;
    strap0 = 1'b1;
    strap1 = 1'b0;
    rx_irq_in_n = 1'b1;
    cmd_ready = 1'b0;
    rsp_valid = 1'b0;
    rsp_data = 8'h00;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check(16'(miso_oe_n), 16'h0001);
    wake_up();
    check(16'(n_wake), 16'h0001);
    check(16'(spi_selected), 16'h0001);
    $display("wake test done");
    poll(2'b01);
    send2(serial_port_pkg::CMD_IDENT);
    poll(2'b00);
    cmd_ready <= 1'b1;
    repeat (10) @(posedge ref_clk);
    check(16'(cq.size()), 16'h0002);
    check(16'(cq[0]), 16'h0101);
    check(16'(cq[1]), 16'h0000);
    check(16'(cmd_kind), 16'(serial_port_pkg::K_IDENT));
    poll(2'b01);
    for (int i = 0; i < 6; i++) begin
      send2(codes[i]);
      check(16'(cmd_kind), 16'(kinds[i]));
    end
    $display("command test done");
    rq.push_back(8'h82);
    rq.push_back(8'h00);
    repeat (10) @(posedge ref_clk);
    check(16'(tx_irq_out_n), 16'h0000);
    poll(2'b11);
    spi_host_model_inst.run(serial_port_pkg::CTL_READ, 24'h0, 2);
    check(spi_host_model_inst.rx_word[15:0], 16'h8200);
    repeat (10) @(posedge ref_clk);
    check(16'(tx_irq_out_n), 16'h0001);
    $display("reply test done");
    send2(serial_port_pkg::CMD_WAIT);
    check(16'(low_power_wait), 16'h0001);
    wake_up();
    check(16'(low_power_wait), 16'h0000);
    check(16'(n_wake), 16'h0002);
    $display("wait test done");
    spi_host_model_inst.run(serial_port_pkg::CTL_RESET, 24'h0, 0);
    check(16'(n_rst), 16'h0001);
    $display("reset test done");
    strap0 <= 1'b0;
    cq.delete();
    wake_up();
    check(16'(spi_selected), 16'h0000);
    fork
      uart_send(serial_port_pkg::CMD_ECHO);
      uart_take(ub);
    join
    check(16'(ub), 16'h0355);
    check(16'(cq.size()), 16'h0000);
    $display("uart test done");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    close_out();
  end
endmodule : test_host_serial_command_port
